// File: hw/fspa_mem.sv
// flash array model: 512 words of 14 bits with registered read
`timescale 1ns/100ps
module fspa_mem (
  input wire logic clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic we, // write the addressed word
  input wire logic re, // read the addressed word
  input wire logic [8:0] addr, // word address
  input wire logic [13:0] wdata, // word to write
  output logic [13:0] rdata // word read, one cycle after re
);
  logic [13:0] cells [0:511];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 14'h0000;
    end else if (re) begin
      rdata <= cells[addr];
    end
  end
endmodule : fspa_mem

// File: hw/fspa_pkg.sv
// types of the flash self-program access block
package fspa_pkg;

  typedef enum logic [2:0] {
    FSPA_IDLE = 3'h1,
    FSPA_PROG = 3'h2,
    FSPA_BULK = 3'h4
  } fspa_state_e;

  typedef struct packed {
    logic erase;
    logic wr_err;
    logic wr_en;
    logic wr_go;
    logic rd_go;
  } fspa_ctrl_s;

  // external programmer request, held until ext_ack
  typedef struct packed {
    logic req;
    logic we;
    logic cfg_we;
    logic bulk;
    logic [8:0] addr;
    logic [13:0] wdata;
  } fspa_ext_req_s;

  typedef struct packed {
    logic ack;
    logic refused;
    logic [13:0] rdata;
  } fspa_ext_rsp_s;

endpackage : fspa_pkg

// File: hw/fspa_regs.svh
// constants of the flash self-program access block
//
// Operation
// RULE1: running program reads and writes flash through control, address and data registers.
// RULE2: flash_word_high:flash_word_low carry the 14-bit flash word.
// RULE3: flash_loc_high:flash_loc_low form a 9-bit word address, up to 512 words.
// RULE4: each write or erase is timed by an internal counter, not software.
// RULE5: code_lock_n at 0 refuses external reads and writes; self-write is unaffected.
// RULE6: only an external bulk erase clears code protection, array and configuration together.
// RULE7: self_program_guard selects a region where self-write and self-erase are blocked.
// RULE8: self_program_guard never limits the external programmer.
// RULE9: only bit 0 of flash_loc_high takes part in the address.
// RULE10: software writes 55h then AAh to flash_key_port, then sets program_kick.
// RULE11: software only sets fetch_trigger and program_kick; hardware clears them on completion.
// RULE12: flash read happens in the second cycle after fetch_trigger; data valid next cycle.
// RULE13: core stalls during a program or erase; clocks and this logic keep running.
`ifndef FSPA_REGS_SVH
`define FSPA_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define FSPA_OFS_CTRL 3'h0
`define FSPA_OFS_KEY 3'h1
`define FSPA_OFS_WORD_LOW 3'h2
`define FSPA_OFS_WORD_HIGH 3'h3
`define FSPA_OFS_LOC_LOW 3'h4
`define FSPA_OFS_LOC_HIGH 3'h5

// ----------------------------------------------------------------------------
// control fields, key values, reset values
// ----------------------------------------------------------------------------
`define FSPA_CTRL_RD_BIT 0
`define FSPA_CTRL_WR_BIT 1
`define FSPA_CTRL_WREN_BIT 2
`define FSPA_CTRL_WRERR_BIT 3
`define FSPA_CTRL_ERASE_BIT 4
`define FSPA_KEY_FIRST 8'h55
`define FSPA_KEY_SECOND 8'hAA
`define FSPA_ERASED_WORD 14'h3FFF
`define FSPA_GUARD_OFF 2'h3
`define FSPA_GUARD_LOW_QUARTER 2'h2
`define FSPA_GUARD_LOW_HALF 2'h1
`define FSPA_GUARD_ALL 2'h0
`define FSPA_LAST_ADDR 9'h01FF

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FSPA_CLK_MHZ 40
`define FSPA_PROG_TIME_US 2000
`define FSPA_PROG_CYCLES (`FSPA_PROG_TIME_US * `FSPA_CLK_MHZ)

`endif

// File: hw/fspa_top.sv
// flash self-program access controller: registers, unlock, timer, protection
`timescale 1ns/100ps
`include "fspa_regs.svh"
module fspa_top #(
  parameter int unsigned PROG_CYCLES = `FSPA_PROG_CYCLES // cycles of one program or erase
) (
  input wire logic clk, // core clock, 40 MHz
  input wire logic nrst, // async reset, active low
  input wire logic [2:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after reg_rd
  output logic core_stall, // core halted for program or erase
  input wire fspa_pkg::fspa_ext_req_s ext_req, // external programmer request
  output fspa_pkg::fspa_ext_rsp_s ext_rsp, // external programmer answer
  output logic code_lock_n, // configuration: 0 = code protected
  output logic [1:0] self_program_guard // configuration: self-write guard
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  fspa_pkg::fspa_state_e state;
  fspa_pkg::fspa_ctrl_s ctrl;
  logic [7:0] word_low;
  logic [5:0] word_high;
  logic [7:0] loc_low;
  logic loc_high;
  logic [1:0] key_step;
  logic [1:0] rd_phase;
  logic [19:0] cnt;
  logic ext_busy;
  logic [13:0] mem_rdata;

  function automatic logic guarded(input logic [8:0] a, input logic [1:0] g);
    unique case (g)
      `FSPA_GUARD_OFF: guarded = 1'b0;
      `FSPA_GUARD_LOW_QUARTER: guarded = (a[8:7] == 2'h0);
      `FSPA_GUARD_LOW_HALF: guarded = !a[8];
      `FSPA_GUARD_ALL: guarded = 1'b1;
    endcase
  endfunction : guarded

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire is_idle = (state == fspa_pkg::FSPA_IDLE);
  wire is_prog = (state == fspa_pkg::FSPA_PROG);
  wire is_bulk = (state == fspa_pkg::FSPA_BULK);
  wire [8:0] core_addr = {loc_high, loc_low}; // RULE3 RULE9
  wire [13:0] core_word = {word_high, word_low}; // RULE2
  wire wr_ctrl = reg_wr && (reg_addr == `FSPA_OFS_CTRL);
  wire wr_key = reg_wr && (reg_addr == `FSPA_OFS_KEY);
  wire key_ok = (key_step == 2'h2);
  wire kick_req = wr_ctrl && reg_wdata[`FSPA_CTRL_WR_BIT] && !ctrl.wr_go && !ctrl.rd_go;
  wire kick_wren = reg_wdata[`FSPA_CTRL_WREN_BIT];
  // unlocked, enabled and outside the guarded region, or the kick is dropped
  wire kick_ok = kick_req && key_ok && kick_wren && !guarded(core_addr, self_program_guard); // RULE7 RULE10
  wire kick_bad = kick_req && !kick_ok;
  wire rd_start = wr_ctrl && reg_wdata[`FSPA_CTRL_RD_BIT] && !ctrl.rd_go && !ctrl.wr_go;
  wire rd_issue = (rd_phase == 2'h2); // RULE12
  wire rd_done = (rd_phase == 2'h3);
  wire prog_done = is_prog && (cnt == 20'(PROG_CYCLES - 1)); // RULE4
  wire bulk_done = is_bulk && (cnt[8:0] == `FSPA_LAST_ADDR);
  // external side only starts when nothing of the core is in flight; guard never consulted
  // a kick in the same cycle wins, else a bulk taken beside it would be acked before it ran
  wire ext_take = ext_req.req && !ext_busy && !ext_rsp.ack && is_idle && !ctrl.rd_go && !ctrl.wr_go
                  && !kick_ok; // RULE8
  wire ext_locked = !code_lock_n && !ext_req.bulk; // RULE5
  wire ext_read = ext_take && !ext_locked && !ext_req.we && !ext_req.cfg_we && !ext_req.bulk;
  wire ext_write = ext_take && !ext_locked && ext_req.we && !ext_req.bulk;

  // --------------------------------------------------------------------------
  // flash port selection
  // --------------------------------------------------------------------------
  wire mem_re = rd_issue || ext_read;
  wire mem_we = prog_done || is_bulk || (ext_write && !ext_req.cfg_we);
  wire [8:0] mem_addr = is_bulk ? cnt[8:0] : ((ext_read || ext_write) ? ext_req.addr : core_addr);
  wire [13:0] mem_wdata = (is_bulk || (prog_done && ctrl.erase)) ? `FSPA_ERASED_WORD
                        : (ext_write ? ext_req.wdata : core_word);

  fspa_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // --------------------------------------------------------------------------
  // next values
  // --------------------------------------------------------------------------
  fspa_pkg::fspa_ctrl_s next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.wr_en = reg_wdata[`FSPA_CTRL_WREN_BIT];
      next_ctrl.erase = reg_wdata[`FSPA_CTRL_ERASE_BIT];
      next_ctrl.wr_err = reg_wdata[`FSPA_CTRL_WRERR_BIT];
    end
    if (rd_start) begin
      next_ctrl.rd_go = 1'b1; // RULE11
    end
    if (rd_done) begin
      next_ctrl.rd_go = 1'b0; // RULE11
    end
    if (kick_ok) begin
      next_ctrl.wr_go = 1'b1; // RULE11
    end
    if (prog_done) begin
      next_ctrl.wr_go = 1'b0; // RULE11
    end
    if (kick_bad) begin
      next_ctrl.wr_err = 1'b1; // set beats a software clear in the same write
    end
  end

  // key must be the very next two writes; any other write breaks the sequence
  wire [1:0] next_key_step = !reg_wr ? key_step
                           : (wr_key && reg_wdata == `FSPA_KEY_FIRST) ? 2'h1
                           : (wr_key && reg_wdata == `FSPA_KEY_SECOND && key_step == 2'h1) ? 2'h2
                           : 2'h0; // RULE10

  wire [7:0] next_rdata = !reg_rd ? 8'h00
    : (reg_addr == `FSPA_OFS_CTRL) ? {3'h0, ctrl.erase, ctrl.wr_err, ctrl.wr_en, ctrl.wr_go, ctrl.rd_go}
    : (reg_addr == `FSPA_OFS_WORD_LOW) ? word_low
    : (reg_addr == `FSPA_OFS_WORD_HIGH) ? {2'h0, word_high}
    : (reg_addr == `FSPA_OFS_LOC_LOW) ? loc_low
    : (reg_addr == `FSPA_OFS_LOC_HIGH) ? {7'h00, loc_high}
    : 8'h00;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '0;
      key_step <= 2'h0;
      reg_rdata <= 8'h00;
      loc_low <= 8'h00;
      loc_high <= 1'b0;
    end else begin
      ctrl <= next_ctrl; // RULE1
      key_step <= next_key_step;
      reg_rdata <= next_rdata;
      if (reg_wr && reg_addr == `FSPA_OFS_LOC_LOW) begin
        loc_low <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSPA_OFS_LOC_HIGH) begin
        loc_high <= reg_wdata[0]; // RULE9
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_low <= 8'h00;
      word_high <= 6'h00;
      rd_phase <= 2'h0;
    end else begin
      rd_phase <= rd_start ? 2'h1 : (rd_phase != 2'h0 ? 2'(rd_phase + 2'h1) : 2'h0); // RULE12
      if (rd_done) begin
        {word_high, word_low} <= mem_rdata; // RULE2 RULE12
      end else begin
        if (reg_wr && reg_addr == `FSPA_OFS_WORD_LOW) begin
          word_low <= reg_wdata;
        end
        if (reg_wr && reg_addr == `FSPA_OFS_WORD_HIGH) begin
          word_high <= reg_wdata[5:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= fspa_pkg::FSPA_IDLE;
      cnt <= 20'h0_0000;
      core_stall <= 1'b0;
    end else begin
      unique case (state)
        fspa_pkg::FSPA_IDLE: begin
          cnt <= 20'h0_0000;
          if (kick_ok) begin
            state <= fspa_pkg::FSPA_PROG;
          end else if (ext_take && ext_req.bulk) begin
            state <= fspa_pkg::FSPA_BULK; // RULE6
          end
        end
        fspa_pkg::FSPA_PROG: begin
          cnt <= 20'(cnt + 20'h0_0001); // RULE4
          if (prog_done) begin
            state <= fspa_pkg::FSPA_IDLE;
          end
        end
        fspa_pkg::FSPA_BULK: begin
          cnt <= 20'(cnt + 20'h0_0001);
          if (bulk_done) begin
            state <= fspa_pkg::FSPA_IDLE;
          end
        end
      endcase
      core_stall <= (kick_ok || is_prog) && !prog_done; // RULE13
    end
  end

  // external programmer answer and the configuration word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_busy <= 1'b0;
      ext_rsp <= '0;
      code_lock_n <= 1'b1;
      self_program_guard <= `FSPA_GUARD_OFF;
    end else begin
      ext_busy <= ext_read || (ext_take && ext_req.bulk) || (ext_busy && !ext_rsp.ack && !is_bulk);
      ext_rsp.ack <= (ext_busy && !is_bulk && !ext_rsp.ack) || bulk_done
                     || (ext_take && !ext_read && !ext_req.bulk);
      ext_rsp.refused <= ext_take && ext_locked; // RULE5
      ext_rsp.rdata <= (ext_busy && !is_bulk && !ext_rsp.ack) ? mem_rdata : 14'h0000;
      if (bulk_done) begin
        code_lock_n <= 1'b1; // RULE6
        self_program_guard <= `FSPA_GUARD_OFF; // RULE6
      end else if (ext_write && ext_req.cfg_we) begin
        code_lock_n <= code_lock_n & ext_req.wdata[7]; // RULE6
        self_program_guard <= ext_req.wdata[12:11];
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_read_walk;
    ctrl.rd_go ##1 (ctrl.rd_go && mem_re && mem_addr == core_addr) ##1 ctrl.rd_go ##1 !ctrl.rd_go;
  endsequence
  property p_read_timing;
    @(posedge clk) disable iff (!nrst) rd_start |=> s_read_walk;
  endproperty
  a_read_timing: assert property (p_read_timing) else $error("flash read not in second cycle"); // RULE12

  property p_read_data;
    @(posedge clk) disable iff (!nrst) rd_issue |-> ##2 (core_word == $past(mem_rdata, 1));
  endproperty
  a_read_data: assert property (p_read_data) else $error("data pair not loaded from flash"); // RULE2

  property p_prog_end;
    @(posedge clk) disable iff (!nrst) prog_done |=> (is_idle && !ctrl.wr_go && !core_stall);
  endproperty
  a_prog_end: assert property (p_prog_end) else $error("program did not end at timer expiry"); // RULE4

  property p_stall;
    @(posedge clk) disable iff (!nrst) kick_ok |=> (core_stall && ctrl.wr_go) ##1 (core_stall && is_prog);
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled during program"); // RULE13

  property p_guard;
    @(posedge clk) disable iff (!nrst) $rose(ctrl.wr_go) |-> !guarded($past(core_addr), self_program_guard);
  endproperty
  a_guard: assert property (p_guard) else $error("self-write started in guarded region"); // RULE7

  property p_unlock;
    @(posedge clk) disable iff (!nrst) $rose(ctrl.wr_go) |-> $past(key_step) == 2'h2;
  endproperty
  a_unlock: assert property (p_unlock) else $error("self-write started without key"); // RULE10

  property p_no_clear;
    @(posedge clk) disable iff (!nrst) (ctrl.wr_go && !prog_done) |=> ctrl.wr_go;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("program_kick dropped early"); // RULE11

  property p_locked;
    @(posedge clk) disable iff (!nrst) (ext_take && ext_locked) |=> (ext_rsp.ack && ext_rsp.refused
      && ext_rsp.rdata == 14'h0000 && !$past(mem_we) && !$past(mem_re));
  endproperty
  a_locked: assert property (p_locked) else $error("locked external access not refused"); // RULE5

  property p_bulk_unlock;
    @(posedge clk) disable iff (!nrst) bulk_done |=> (code_lock_n && self_program_guard == 2'h3 && ext_rsp.ack);
  endproperty
  a_bulk_unlock: assert property (p_bulk_unlock) else $error("bulk erase left protection set"); // RULE6

endmodule : fspa_top

// File: hw/fspa_top_placeholder_unused.sv
// spare file: holds no logic

// File: sim/fspa_ext_model.sv
// external programmer model driving the programmer request port
`timescale 1ns/100ps
module fspa_ext_model (
  input wire logic clk, // core clock
  output fspa_pkg::fspa_ext_req_s ext_req, // request to the block
  input wire fspa_pkg::fspa_ext_rsp_s ext_rsp // answer from the block
);
  initial ext_req = '0;
  // request held until ack; released fields are inverted so a stale value never looks valid
  task automatic xfer(input logic we, input logic cfg, input logic bulk, input logic [8:0] a,
                      input logic [13:0] d, output fspa_pkg::fspa_ext_rsp_s r, output logic ok);
    fspa_pkg::fspa_ext_req_s q;
    int n;
    q = {1'b1, we, cfg, bulk, a, d};
    n = 0;
    @(posedge clk);
    ext_req <= q;
    do begin
      @(posedge clk);
      n++;
    end while (ext_rsp.ack !== 1'b1 && n < 2000);
    r = ext_rsp;
    ok = (n < 2000);
    q = ~q;
    q.req = 1'b0;
    ext_req <= q;
  endtask : xfer
endmodule : fspa_ext_model

// File: sim/fspa_top_test.sv
// self-checking bench of the flash self-program access controller
`timescale 1ns/100ps
`include "fspa_regs.svh"
module fspa_top_test;
  localparam int PROG = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic core_stall;
  logic code_lock_n;
  logic [1:0] self_program_guard;
  fspa_pkg::fspa_ext_req_s ext_req;
  fspa_pkg::fspa_ext_rsp_s ext_rsp;
  fspa_pkg::fspa_ext_rsp_s rsp;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 44;
  logic [13:0] mem [512];
  logic m_lock = 1'b1;
  logic [1:0] m_guard = 2'h3;
  logic [7:0] rd_v;
  logic ok;
  logic [8:0] ra;
  logic [13:0] rdat;

  always #12.5 clk = ~clk;

  fspa_top #(.PROG_CYCLES(PROG)) dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_stall(core_stall), .ext_req(ext_req),
    .ext_rsp(ext_rsp), .code_lock_n(code_lock_n), .self_program_guard(self_program_guard));
  fspa_ext_model ext_u (.clk(clk), .ext_req(ext_req), .ext_rsp(ext_rsp));

  // ----------------------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd

  // junk in the upper address bits must not move the word
  task automatic set_loc(input logic [8:0] a);
    wr(`FSPA_OFS_LOC_LOW, a[7:0]);
    wr(`FSPA_OFS_LOC_HIGH, {7'h55, a[8]});
  endtask : set_loc

  task automatic self_prog(input logic [8:0] a, input logic [13:0] d, input logic erase, input logic brk);
    logic blk;
    int n;
    blk = brk || m_guard == 2'h0 || (m_guard == 2'h1 && a < 9'h100) || (m_guard == 2'h2 && a < 9'h080);
    n = 0;
    set_loc(a);
    wr(`FSPA_OFS_WORD_LOW, d[7:0]);
    wr(`FSPA_OFS_WORD_HIGH, {2'b11, d[13:8]});
    wr(`FSPA_OFS_KEY, 8'h55);
    if (brk) wr(`FSPA_OFS_WORD_LOW, d[7:0]);
    wr(`FSPA_OFS_KEY, 8'hAA);
    wr(`FSPA_OFS_CTRL, erase ? 8'h16 : 8'h06);
    // first look lands in the cycle right after the kick edge
    repeat (PROG + 8) begin
      #1 if (core_stall === 1'b1) n++;
      @(posedge clk);
    end
    chk(n[15:0], blk ? 16'h0000 : 16'(PROG));
    if (!blk) mem[a] = erase ? 14'h3FFF : d;
    rd(`FSPA_OFS_CTRL);
    chk(rd_v[1:0], 16'h0000);
    chk(rd_v[3], blk);
  endtask : self_prog

  task automatic self_read(input logic [8:0] a);
    logic [7:0] lo;
    set_loc(a);
    wr(`FSPA_OFS_CTRL, 8'h01);
    repeat (4) @(posedge clk);
    rd(`FSPA_OFS_WORD_LOW);
    lo = rd_v;
    rd(`FSPA_OFS_WORD_HIGH);
    chk({rd_v, lo}, {2'b00, mem[a]});
    rd(`FSPA_OFS_CTRL);
    chk(rd_v[0], 16'h0000);
  endtask : self_read

  task automatic ext(input logic we, input logic cfg, input logic bulk, input logic [8:0] a, input logic [13:0] d);
    ext_u.xfer(we, cfg, bulk, a, d, rsp, ok);
    chk(ok, 16'h0001);
    if (!bulk) chk(rsp.refused, !m_lock);
    if (!we && !bulk) chk(rsp.rdata, m_lock ? mem[a] : 14'h0000);
    if (we && !cfg && m_lock) mem[a] = d;
    if (cfg && m_lock) begin
      m_lock = m_lock & d[7];
      m_guard = d[12:11];
    end
    if (bulk) begin
      foreach (mem[i]) mem[i] = 14'h3FFF;
      m_lock = 1'b1;
      m_guard = 2'h3;
    end
    @(posedge clk);
    #1 chk({code_lock_n, self_program_guard}, {m_lock, m_guard});
  endtask : ext

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk({code_lock_n, self_program_guard, core_stall}, 16'h000E);
    rd(3'h6);
    chk(rd_v, 16'h0000);
    rd(3'h7);
    chk(rd_v, 16'h0000);
    rd(`FSPA_OFS_KEY);
    chk(rd_v, 16'h0000);
    // array content is not reset, so start from a known erased state
    ext(1'b0, 1'b0, 1'b1, 9'h000, 14'h0000);
    self_read(9'h1FF);
    self_prog(9'h1A5, 14'h2C3B, 1'b0, 1'b0);
    self_read(9'h1A5);
    ext(1'b0, 1'b0, 1'b0, 9'h1A5, 14'h0000);
    self_prog(9'h1A5, 14'h1111, 1'b0, 1'b1);
    self_read(9'h1A5);
    self_prog(9'h1A5, 14'h0000, 1'b1, 1'b0);
    self_read(9'h1A5);
    for (int g = 0; g < 4; g++) begin
      ext(1'b1, 1'b1, 1'b0, 9'h000, {1'b0, 2'(g), 3'h0, 1'b1, 7'h00});
      for (int k = 0; k < 4; k++) begin
        ra = (k == 0) ? 9'h07F : (k == 1) ? 9'h080 : (k == 2) ? 9'h0FF : 9'h100;
        self_prog(ra, 14'($random(seed)), 1'b0, 1'b0);
        self_read(ra);
        ext(1'b1, 1'b0, 1'b0, ra, 14'($random(seed)));
        self_read(ra);
      end
    end
    repeat (6) begin
      ra = 9'($random(seed));
      rdat = 14'($random(seed));
      ext(1'b1, 1'b0, 1'b0, ra, rdat);
      ext(1'b0, 1'b0, 1'b0, ra, 14'h0000);
    end
    ext(1'b1, 1'b1, 1'b0, 9'h000, 14'h1800);
    ext(1'b0, 1'b0, 1'b0, 9'h1A5, 14'h0000);
    ext(1'b1, 1'b0, 1'b0, 9'h010, 14'h0ABC);
    self_read(9'h010);
    self_prog(9'h010, 14'h3456, 1'b0, 1'b0);
    self_read(9'h010);
    ext(1'b0, 1'b0, 1'b1, 9'h000, 14'h0000);
    ext(1'b0, 1'b0, 1'b0, 9'h010, 14'h0000);
    self_read(9'h1A5);
    end_sim();
  end

  initial begin
    #(25 * 40000);
    error_cnt++;
    end_sim();
  end
endmodule : fspa_top_test
